//--- rtl/bsc_cfg.svh
/*
  constants of the bit-test, clear and call execution unit: register map, field
  positions, reset values, opcode patterns and file addresses.
  assumes inclusion by bare name from every file that needs a figure.
*/
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// apb register byte addresses
`define ADDR_INSTR      12'h000
`define ADDR_CTRL       12'h004
`define ADDR_STATUS     12'h008
`define ADDR_PC         12'h00c
`define ADDR_WORK       12'h010
`define ADDR_STACK_TOP  12'h014

// control register fields
`define CTRL_PRESC_BIT  0
`define CTRL_PAGE_LSB   8
`define CTRL_PAGE_MSB   12

// status register fields
`define STAT_ZERO_BIT   0
`define STAT_BUSY_BIT   1
`define STAT_DISC_BIT   2
`define STAT_TO_BIT     3
`define STAT_PD_BIT     4

// reset values
`define RST_PC          13'h0000
`define RST_WORK        8'h00
`define RST_PAGE        5'h00
`define RST_TO          1'b1
`define RST_PD          1'b1

// opcode patterns
`define OPC_SKIP_SET    4'h7
`define OPC_SKIP_CLEAR  4'h6
`define OPC_CLEAR_FILE  7'h03
`define OPC_CLEAR_WORK  7'h02
`define OPC_CALL        3'h4
`define OPC_CLEAR_WDT   14'h0064

// file register addresses and cleared value
`define FILE_TIMER_ZERO 7'h01
`define FILE_PORT_B     7'h06
`define CLEAR_VALUE     8'h00

// return stack geometry
`define STACK_AW        3
`define STACK_DEPTH     8
`define PC_W            13

`endif

//--- rtl/bsc_pkg.sv
/*
  types of the bit-test, clear and call execution unit.
  assumes nothing of its surroundings.
*/
package bsc_pkg;

  typedef enum logic [2:0] {
    OP_SKIP_SET,
    OP_SKIP_CLEAR,
    OP_CLEAR_FILE,
    OP_CLEAR_WORK,
    OP_CALL,
    OP_CLEAR_WDT,
    OP_OTHER
  } op_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_NOP
  } state_type;

endpackage

//--- rtl/return_stack.sv
/*
  return address stack storage: one write port, one read port whose data
  come out of a register one edge after the address.
  assumes the caller keeps the pointer and wraps it.
*/
`timescale 1ns/1ps
`include "bsc_cfg.svh"
module return_stack (
  input  wire logic                    pclk,    // core clock
  input  wire logic                    pce,     // clock enable
  input  wire logic                    wr_en,   // write strobe
  input  wire logic [`STACK_AW-1:0]    wr_addr, // write slot
  input  wire logic [`PC_W-1:0]        wr_data, // return address
  input  wire logic [`STACK_AW-1:0]    rd_addr, // read slot
  output logic      [`PC_W-1:0]        rd_data  // registered read data
);
  logic [`PC_W-1:0] mem [`STACK_DEPTH];

  always_ff @(posedge pclk) begin
    if (pce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk) begin
    if (pce) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

//--- rtl/bit_skip_call_clear_exec.sv
/*
  execution unit for bit-test-and-skip, clear file, clear work, call and
  clear watchdog, fed one instruction word at a time over apb.
  assumes an asynchronous-read data file on the same clock, a watchdog and
  timer prescaler that take one-cycle clear pulses, and port b pins that are
  asynchronous to pclk.
*/
`timescale 1ns/1ps
`include "bsc_cfg.svh"
module bit_skip_call_clear_exec (
  input  wire logic              pclk,           // core clock
  input  wire logic              presetn,        // async reset, low active
  input  wire logic              pce,            // clock enable, freezes all
  input  wire logic              psel,           // apb select
  input  wire logic              penable,        // apb access phase
  input  wire logic              pwrite,         // apb write
  input  wire logic [11:0]       paddr,          // apb byte address
  input  wire logic [31:0]       pwdata,         // apb write data
  output logic      [31:0]       prdata,         // apb read data
  output logic                   pready,         // apb ready
  output logic                   pslverr,        // apb error
  input  wire logic [7:0]        port_b_pins,    // port b pin levels
  output logic      [6:0]        file_addr,      // data file address
  input  wire logic [7:0]        file_rdata,     // data file read data
  output logic                   file_we,        // data file write pulse
  output logic      [7:0]        file_wdata,     // data file write data
  output logic                   presc_clear,    // timer prescaler clear pulse
  output logic                   wdt_clear,      // watchdog and its prescaler clear
  input  wire logic              wdt_timeout,    // watchdog expired, clears timeout
  input  wire logic              sleep_entry,    // sleep entered, clears powerdown
  output bsc_pkg::state_type     cycle_state     // execution cycle state
);
  import bsc_pkg::*;

  logic [7:0]        pin_meta;
  logic [7:0]        pin_sync;
  logic [13:0]       instr;
  logic [12:0]       program_counter;
  logic [7:0]        work_reg;
  logic              zero_flag;
  logic              timeout_flag;
  logic              powerdown_flag;
  logic              presc_assign;
  logic [4:0]        program_page_latch;
  logic              discard_pending;
  logic [2:0]        stack_ptr;
  logic [12:0]       stack_top;
  logic [12:0]       pc_plus_one;
  state_type         state;
  op_type            exec_op;
  op_type            issue_op;
  logic [7:0]        operand;
  logic              test_bit;
  logic              skip_taken;
  logic              instr_req;
  logic              wr_done;
  logic              issue;
  logic              start;
  logic              drop;
  logic              push;
  logic [31:0]       next_rdata;

  function automatic op_type decode_op(input logic [13:0] w);
    if (w[13:10] == `OPC_SKIP_SET) begin
      return OP_SKIP_SET;
    end else if (w[13:10] == `OPC_SKIP_CLEAR) begin
      return OP_SKIP_CLEAR;
    end else if (w[13:7] == `OPC_CLEAR_FILE) begin
      return OP_CLEAR_FILE;
    end else if (w[13:7] == `OPC_CLEAR_WORK) begin
      return OP_CLEAR_WORK;
    end else if (w[13:11] == `OPC_CALL) begin
      return OP_CALL;
    end else if (w == `OPC_CLEAR_WDT) begin
      return OP_CLEAR_WDT;
    end
    return OP_OTHER;
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == `ADDR_INSTR) || (a == `ADDR_CTRL) || (a == `ADDR_STATUS) ||
           (a == `ADDR_PC) || (a == `ADDR_WORK) || (a == `ADDR_STACK_TOP);
  endfunction

  assign exec_op     = decode_op(instr);
  assign issue_op    = decode_op(pwdata[13:0]);
  assign cycle_state = state;
  assign pc_plus_one = program_counter + 13'h0001;

  // port b pins cross into pclk through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else if (pce) begin
      pin_meta <= port_b_pins;
      pin_sync <= pin_meta;
    end
  end

  // an instruction word is only taken when the unit is idle
  assign instr_req = psel && penable && pwrite && (paddr == `ADDR_INSTR);
  assign pready    = pce && !(instr_req && (state != ST_IDLE));
  assign pslverr   = psel && penable && !addr_mapped(paddr);
  assign wr_done   = psel && penable && pwrite && pready;
  assign issue     = wr_done && (paddr == `ADDR_INSTR);
  assign drop      = issue && discard_pending;
  assign start     = issue && !discard_pending;
  assign push      = (state == ST_EXEC) && (exec_op == OP_CALL);

  always_comb begin
    operand = (file_addr == `FILE_PORT_B) ? pin_sync : file_rdata;
    test_bit = operand[instr[9:7]];
    skip_taken = (state == ST_EXEC) &&
                 (((exec_op == OP_SKIP_SET) && test_bit) ||
                  ((exec_op == OP_SKIP_CLEAR) && !test_bit));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (pce) begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (push || skip_taken) begin
            state <= ST_NOP;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_NOP: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= 14'h0000;
      file_addr <= 7'h00;
    end else if (pce && start) begin
      instr <= pwdata[13:0];
      file_addr <= pwdata[6:0];
    end
  end

  // side-effect pulses are issued with the word so they stand in the exec cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_we <= 1'b0;
      file_wdata <= `CLEAR_VALUE;
      presc_clear <= 1'b0;
      wdt_clear <= 1'b0;
    end else if (pce) begin
      file_we <= start && (issue_op == OP_CLEAR_FILE);
      file_wdata <= `CLEAR_VALUE;
      presc_clear <= start && (issue_op == OP_CLEAR_FILE) &&
                     (pwdata[6:0] == `FILE_TIMER_ZERO) && presc_assign;
      wdt_clear <= start && (issue_op == OP_CLEAR_WDT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= `RST_PC;
    end else if (pce) begin
      if (push) begin
        program_counter <= {program_page_latch[4:3], instr[10:0]};
      end else if (state == ST_EXEC || drop) begin
        program_counter <= pc_plus_one;
      end else if (wr_done && paddr == `ADDR_PC) begin
        program_counter <= pwdata[12:0];
      end
    end
  end

  // a taken skip leaves the following word to be swallowed on arrival
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discard_pending <= 1'b0;
    end else if (pce) begin
      if (skip_taken) begin
        discard_pending <= 1'b1;
      end else if (drop) begin
        discard_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_reg <= `RST_WORK;
    end else if (pce && state == ST_EXEC && exec_op == OP_CLEAR_WORK) begin
      work_reg <= `CLEAR_VALUE;
    end
  end

  // bit tests and call never reach the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_flag <= 1'b0;
    end else if (pce) begin
      if (state == ST_EXEC &&
          (exec_op == OP_CLEAR_FILE || exec_op == OP_CLEAR_WORK)) begin
        zero_flag <= 1'b1;
      end else if (wr_done && paddr == `ADDR_STATUS) begin
        zero_flag <= pwdata[`STAT_ZERO_BIT];
      end
    end
  end

  // the clear instruction wins over a simultaneous timeout or sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= `RST_TO;
      powerdown_flag <= `RST_PD;
    end else if (pce) begin
      if (state == ST_EXEC && exec_op == OP_CLEAR_WDT) begin
        timeout_flag <= 1'b1;
        powerdown_flag <= 1'b1;
      end else begin
        if (wdt_timeout) begin
          timeout_flag <= 1'b0;
        end
        if (sleep_entry) begin
          powerdown_flag <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_assign <= 1'b0;
      program_page_latch <= `RST_PAGE;
    end else if (pce && wr_done && paddr == `ADDR_CTRL) begin
      presc_assign <= pwdata[`CTRL_PRESC_BIT];
      program_page_latch <= pwdata[`CTRL_PAGE_MSB:`CTRL_PAGE_LSB];
    end
  end

  // pointer wraps, so a ninth push overwrites the oldest entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_ptr <= 3'h0;
    end else if (pce && push) begin
      stack_ptr <= stack_ptr + 3'h1;
    end
  end

  return_stack return_stack_inst (
    .pclk    (pclk),
    .pce     (pce),
    .wr_en   (push),
    .wr_addr (stack_ptr),
    .wr_data (pc_plus_one),
    .rd_addr (stack_ptr - 3'h1),
    .rd_data (stack_top)
  );

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      `ADDR_INSTR: next_rdata[13:0] = instr;
      `ADDR_CTRL: begin
        next_rdata[`CTRL_PRESC_BIT] = presc_assign;
        next_rdata[`CTRL_PAGE_MSB:`CTRL_PAGE_LSB] = program_page_latch;
      end
      `ADDR_STATUS: begin
        next_rdata[`STAT_ZERO_BIT] = zero_flag;
        next_rdata[`STAT_BUSY_BIT] = (state != ST_IDLE);
        next_rdata[`STAT_DISC_BIT] = discard_pending;
        next_rdata[`STAT_TO_BIT] = timeout_flag;
        next_rdata[`STAT_PD_BIT] = powerdown_flag;
      end
      `ADDR_PC: next_rdata[12:0] = program_counter;
      `ADDR_WORK: next_rdata[7:0] = work_reg;
      `ADDR_STACK_TOP: next_rdata[12:0] = stack_top;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup phase, so reads wait only while pce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (pce && psel && !penable) begin
      prdata <= next_rdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_nop_idle;
    state == ST_NOP ##1 state == ST_IDLE;
  endsequence

  sequence seq_flags_kept;
    $stable(zero_flag) && $stable(timeout_flag) && $stable(powerdown_flag);
  endsequence

  a_pin_operand: assert property (
    state == ST_EXEC && exec_op == OP_SKIP_SET && file_addr == `FILE_PORT_B
    |=> (state == ST_NOP) == $past(pin_sync[instr[9:7]]))
    else $error("port b test did not use pin levels");

  a_presc_clear: assert property (
    presc_clear |-> state == ST_EXEC && exec_op == OP_CLEAR_FILE &&
                    file_addr == `FILE_TIMER_ZERO && presc_assign)
    else $error("prescaler clear without timer zero clear");

  a_two_cycle: assert property (
    pce && state == ST_EXEC && (push || skip_taken) |=> seq_nop_idle)
    else $error("pc change or true test not two cycles");

  a_skip_set: assert property (
    pce && state == ST_EXEC && exec_op == OP_SKIP_SET
    |=> discard_pending == $past(test_bit) && program_counter == $past(pc_plus_one))
    else $error("skip if set outcome wrong");

  a_skip_clear: assert property (
    pce && state == ST_EXEC && exec_op == OP_SKIP_CLEAR
    |=> discard_pending == !$past(test_bit) && state != ST_EXEC)
    else $error("skip if clear outcome wrong");

  a_skip_flags: assert property (
    state == ST_EXEC && (exec_op == OP_SKIP_SET || exec_op == OP_SKIP_CLEAR) &&
    !wdt_timeout && !sleep_entry |=> seq_flags_kept)
    else $error("bit test changed a flag");

  a_clear_file: assert property (
    pce && state == ST_EXEC && exec_op == OP_CLEAR_FILE
    |-> file_we && file_wdata == `CLEAR_VALUE ##1 zero_flag && !file_we)
    else $error("clear file did not write zero and set zero flag");

  a_clear_work: assert property (
    pce && state == ST_EXEC && exec_op == OP_CLEAR_WORK
    |=> work_reg == `CLEAR_VALUE && zero_flag)
    else $error("clear work failed");

  a_call_push: assert property (
    pce && push ##1 pce
    |-> program_counter == {$past(program_page_latch[4:3]), $past(instr[10:0])}
        ##1 stack_top == $past(pc_plus_one, 2))
    else $error("call target or return address wrong");

  a_call_flags: assert property (
    push && !wdt_timeout && !sleep_entry |=> seq_flags_kept and state == ST_NOP)
    else $error("call touched flags or was not two cycles");

  a_clear_wdt: assert property (
    pce && state == ST_EXEC && exec_op == OP_CLEAR_WDT
    |-> wdt_clear ##1 timeout_flag && powerdown_flag)
    else $error("clear watchdog failed");

  a_decode_set: assert property (
    state == ST_EXEC && instr[13:10] == 4'h7 |-> exec_op == OP_SKIP_SET)
    else $error("skip if set not decoded");

  a_decode_clear: assert property (
    state == ST_EXEC && instr[13:10] == 4'h6 |-> exec_op == OP_SKIP_CLEAR)
    else $error("skip if clear not decoded");

  a_discard_word: assert property (
    pce && drop |=> program_counter == $past(pc_plus_one) && state == ST_IDLE &&
                    $stable(work_reg) && $stable(zero_flag) && !discard_pending)
    else $error("discarded word had an effect");
endmodule

//--- sim/bit_skip_call_clear_exec_test.sv
/*
  self-checking bench for the bit-test, clear, call and clear-watchdog unit:
  apb master tasks, a small data file model and one task per scenario.
  assumes the register map and opcode patterns of bsc_cfg.svh; pce is held high
  except in the freeze check.
*/
`timescale 1ns/1ps
`include "bsc_cfg.svh"
module bit_skip_call_clear_exec_test;
  import bsc_pkg::*;

  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        pce         = 1'b1;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  port_b_pins = 8'h00;
  logic [6:0]  file_addr;
  logic [7:0]  file_rdata;
  logic        file_we;
  logic [7:0]  file_wdata;
  logic        presc_clear;
  logic        wdt_clear;
  logic        wdt_timeout = 1'b0;
  logic        sleep_entry = 1'b0;
  state_type   cycle_state;
  logic [7:0]  mem [128];
  int          n_fail      = 0;
  int          check_count = 0;
  logic [31:0] rd_val;
  logic        rd_err;
  logic        seen_we;
  logic        seen_presc;
  logic        seen_wdt;

  always #5 pclk = ~pclk;

  // data file model: asynchronous read, written on the pulse
  assign file_rdata = mem[file_addr];
  always @(posedge pclk) begin
    if (file_we === 1'b1) begin
      mem[file_addr] <= file_wdata;
    end
  end

  bit_skip_call_clear_exec bit_skip_call_clear_exec_inst (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_b_pins(port_b_pins),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_wdata(file_wdata), .presc_clear(presc_clear), .wdt_clear(wdt_clear),
    .wdt_timeout(wdt_timeout), .sleep_entry(sleep_entry), .cycle_state(cycle_state)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // the request stands until pready is seen high at a rising edge; data are taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_val = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic issue(input logic [13:0] instr, input logic two);
    apb(1'b1, `ADDR_INSTR, {18'h0, instr});
    @(negedge pclk);
    chk(32'(cycle_state), 32'(ST_EXEC));
    seen_we    = file_we;
    seen_presc = presc_clear;
    seen_wdt   = wdt_clear;
    @(negedge pclk);
    chk(32'(cycle_state), 32'(two ? ST_NOP : ST_IDLE));
  endtask

  // the word after a taken skip must not start an execution cycle
  task automatic drop(input logic [13:0] instr);
    apb(1'b1, `ADDR_INSTR, {18'h0, instr});
    @(negedge pclk);
    chk(32'(cycle_state), 32'(ST_IDLE));
    chk(32'(file_we), 32'h0);
  endtask

  task automatic t_reset;
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd_val, 32'h0000_0018);
    apb(1'b0, 12'h018, 32'h0);
    chk({rd_val[30:0], rd_err}, 32'h0000_0001);
    $display("reset test done");
  endtask

  task automatic t_clear;
    logic [31:0] pc0;
    mem[7'h30] = 8'h5a;
    apb(1'b1, `ADDR_STATUS, 32'h0);
    issue({7'h03, 7'h30}, 1'b0);
    chk(32'(seen_we), 32'h1);
    chk(32'(seen_presc), 32'h0);
    chk(32'(mem[7'h30]), 32'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(32'(rd_val[4:0]), 32'h19);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `ADDR_CTRL, 32'(i));
      issue({7'h03, `FILE_TIMER_ZERO}, 1'b0);
      chk(32'(seen_presc), 32'(i));
    end
    apb(1'b1, `ADDR_STATUS, 32'h0);
    apb(1'b0, `ADDR_PC, 32'h0);
    pc0 = rd_val;
    issue({7'h02, 7'h00}, 1'b0);
    apb(1'b0, `ADDR_WORK, 32'h0);
    chk(rd_val, 32'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(32'(rd_val[0]), 32'h1);
    apb(1'b0, `ADDR_PC, 32'h0);
    chk(rd_val, pc0 + 32'h1);
    $display("clear test done");
  endtask

  task automatic t_skip;
    logic [13:0] op [4];
    logic        tk [4];
    logic [31:0] pc0;
    // bit 7 and bit 0 set, the rest clear, at the top file address
    op = '{{4'h7, 3'd7, 7'h7f}, {4'h7, 3'd3, 7'h7f}, {4'h6, 3'd0, 7'h7f}, {4'h6, 3'd6, 7'h7f}};
    tk = '{1'b1, 1'b0, 1'b0, 1'b1};
    mem[7'h7f] = 8'h81;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `ADDR_STATUS, 32'h0);
      apb(1'b0, `ADDR_PC, 32'h0);
      pc0 = rd_val;
      issue(op[i], tk[i]);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(32'(rd_val[2]), 32'(tk[i]));
      chk(32'(rd_val[0]), 32'h0);
      if (tk[i]) drop({7'h03, 7'h7f});
      chk(32'(mem[7'h7f]), 32'h81);
      apb(1'b0, `ADDR_PC, 32'h0);
      chk(rd_val, pc0 + (tk[i] ? 32'h2 : 32'h1));
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(32'(rd_val[2:0]), 32'h0);
    end
    $display("skip test done");
  endtask

  // latch and pins disagree, so only the pin level can give the expected skip
  task automatic t_port;
    mem[`FILE_PORT_B] = 8'hff;
    @(posedge pclk);
    port_b_pins <= 8'h00;
    repeat (4) @(posedge pclk);
    issue({4'h6, 3'd2, `FILE_PORT_B}, 1'b1);
    drop({7'h02, 7'h00});
    mem[`FILE_PORT_B] = 8'h00;
    @(posedge pclk);
    port_b_pins <= 8'h04;
    repeat (4) @(posedge pclk);
    issue({4'h7, 3'd2, `FILE_PORT_B}, 1'b1);
    drop({7'h02, 7'h00});
    $display("port test done");
  endtask

  task automatic t_call;
    logic [12:0] pc_in [2];
    logic [10:0] k [2];
    logic [4:0]  pg [2];
    pc_in = '{13'h0123, 13'h1ffe};
    k     = '{11'h7ff, 11'h000};
    pg    = '{5'h1a, 5'h07};
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `ADDR_CTRL, {19'h0, pg[i], 8'h00});
      apb(1'b1, `ADDR_PC, {19'h0, pc_in[i]});
      apb(1'b1, `ADDR_STATUS, 32'h1);
      issue({`OPC_CALL, k[i]}, 1'b1);
      apb(1'b0, `ADDR_PC, 32'h0);
      chk(rd_val, {19'h0, pg[i][4:3], k[i]});
      apb(1'b0, `ADDR_STACK_TOP, 32'h0);
      chk(rd_val, {19'h0, pc_in[i] + 13'h1});
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(32'(rd_val[0]), 32'h1);
    end
    $display("call test done");
  endtask

  task automatic t_wdt;
    // with the clock enable low the flags must ignore timeout and sleep
    @(posedge pclk);
    pce         <= 1'b0;
    wdt_timeout <= 1'b1;
    sleep_entry <= 1'b1;
    repeat (2) @(posedge pclk);
    pce         <= 1'b1;
    wdt_timeout <= 1'b0;
    sleep_entry <= 1'b0;
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(32'(rd_val[4:3]), 32'h3);
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    sleep_entry <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    sleep_entry <= 1'b0;
    apb(1'b1, `ADDR_STATUS, 32'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(32'(rd_val[4:0]), 32'h00);
    issue(`OPC_CLEAR_WDT, 1'b0);
    chk(32'(seen_wdt), 32'h1);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(32'(rd_val[4:0]), 32'h18);
    $display("watchdog test done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_clear;
    t_skip;
    t_port;
    t_call;
    t_wdt;
    stop_test;
  end

  // the whole sequence needs well under a thousand cycles; this allows ample margin
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
endmodule
